// File: rtl/latm_trap_monitor.sv
// Legacy access trap monitor: host bus snoop, trap status, interrupt
// routing and inactivity timer reload requests.
// Assumes host bus snoop and IO register port on core_clk_i; IRQ, bus
// master request lines arrive from pins and are synchronised here.
`timescale 1ns/1ps

// Summary of operation
// RULE_01 - IO access to 1F0-1F7h or 3F6h flags primary IDE trap bit 0/1
// RULE_02 - IO access to 170-177h or 376h flags secondary IDE trap bit 2/3
// RULE_03 - Drive/head register bit 4 picks master (0) or slave (1)
// RULE_04 - Native mode channels decode from their programmed base addresses
// RULE_05 - Floppy register ranges and extra ports set trap bit 4
// RULE_06 - Any of three parallel port ranges sets trap bit 5
// RULE_07 - Video IO range or frame buffer memory window sets trap bit 9
// RULE_08 - Keyboard ports 60h and 64h set trap bit 10
// RULE_09 - Serial, audio, card, IO and memory monitors decode programmed ranges
// RULE_10 - End of a USB transfer sets trap bit 13
// RULE_11 - Trap sets its status bit; software clears it by writing 1
// RULE_12 - Enabled status raises SCI when routed there, otherwise SMI
// RULE_13 - Any enabled status bit asserts the aggregate trap event flag
// RULE_14 - Trap with reload enable set reloads the inactivity timer
// RULE_15 - External SMI status reloads and holds the timer when enabled
// RULE_16 - Bus master request reloads the timer when enabled
// RULE_17 - Enabled IRQ line transition reloads timer; bit 2 is INTR
// RULE_18 - Each enabled reload event loads the programmed reload value
// RULE_19 - Trap event wins over a same-cycle write-1-to-clear
// RULE_20 - One trap pulse per completed IO or memory host cycle
module latm_trap_monitor (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Host bus snoop
    input wire logic hb_done_i,
    input wire logic hb_is_mem_i,
    input wire logic hb_is_write_i,
    input wire logic [31:0] hb_addr_i,
    input wire logic [7:0] hb_wdata_i,
    // IDE native mode configuration
    input wire logic ide_pri_native_i,
    input wire logic [15:0] ide_pri_cmd_base_i,
    input wire logic [15:0] ide_pri_ctl_base_i,
    input wire logic ide_sec_native_i,
    input wire logic [15:0] ide_sec_cmd_base_i,
    input wire logic [15:0] ide_sec_ctl_base_i,
    // Programmable ranges, one 32-bit word per slot
    input wire logic [latm_pkg::NUM_RANGES-1:0] range_en_i,
    input wire logic [latm_pkg::NUM_RANGES*32-1:0] range_base_i,
    input wire logic [latm_pkg::NUM_RANGES*32-1:0] range_mask_i,
    // Other activity sources
    input wire logic usb_xfer_end_i,
    input wire logic external_smi_flag_i,
    input wire logic sci_routing_enable_i,
    input wire logic [latm_pkg::NUM_BMREQ-1:0] bus_master_req_i,
    input wire logic [latm_pkg::NUM_IRQS-1:0] irq_line_i,
    // IO register port
    input wire logic [7:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [3:0] io_be_i,
    input wire logic [31:0] io_wdata_i,
    output logic [31:0] io_rdata_o,
    // Interrupt and timer outputs
    output logic smi_o,
    output logic sci_o,
    output logic any_trap_event_flag_o,
    output logic inactivity_reload_o,
    output logic inactivity_hold_o
);

    // Register state
    logic [latm_pkg::NUM_TRAPS-1:0] trap_status;
    logic [latm_pkg::NUM_TRAPS-1:0] trap_interrupt_enable;
    logic [latm_pkg::RLD_BITS-1:0] trap_timer_reload_enable;
    logic [latm_pkg::NUM_IRQS-1:0] irq_timer_reload_enable;
    logic pri_head_sel;
    logic sec_head_sel;
    logic ext_smi_prev;

    // Pin synchronisers
    logic [latm_pkg::NUM_IRQS-1:0] irq_meta;
    logic [latm_pkg::NUM_IRQS-1:0] irq_sync;
    logic [latm_pkg::NUM_IRQS-1:0] irq_prev;
    logic [latm_pkg::NUM_BMREQ-1:0] bmreq_meta;
    logic [latm_pkg::NUM_BMREQ-1:0] bmreq_sync;

    // Address decode
    wire io_cycle = hb_done_i & ~hb_is_mem_i;
    wire mem_cycle = hb_done_i & hb_is_mem_i;
    wire [15:0] io_a = hb_addr_i[15:0];
    wire upper_zero = (hb_addr_i[31:16] == 16'h0000);

    // Primary channel decode, fixed or native
    wire [15:0] pri_cmd = ide_pri_native_i ? ide_pri_cmd_base_i
                                           : latm_pkg::IDE_PRI_CMD;
    wire [15:0] pri_ctl = ide_pri_native_i
        ? ide_pri_ctl_base_i + latm_pkg::IDE_NAT_CTL_OFS
        : latm_pkg::IDE_PRI_CTL; // [RULE_04]
    wire pri_cmd_hit = upper_zero && (io_a[15:3] == pri_cmd[15:3]);
    wire pri_hit = io_cycle &&
        (pri_cmd_hit || (upper_zero && io_a == pri_ctl)); // [RULE_01]
    wire pri_head_wr = io_cycle && hb_is_write_i && upper_zero &&
        (io_a == (pri_cmd | latm_pkg::IDE_HEAD_OFS));

    // Secondary channel decode, fixed or native
    wire [15:0] sec_cmd = ide_sec_native_i ? ide_sec_cmd_base_i
                                           : latm_pkg::IDE_SEC_CMD;
    wire [15:0] sec_ctl = ide_sec_native_i
        ? ide_sec_ctl_base_i + latm_pkg::IDE_NAT_CTL_OFS
        : latm_pkg::IDE_SEC_CTL; // [RULE_04]
    wire sec_cmd_hit = upper_zero && (io_a[15:3] == sec_cmd[15:3]);
    wire sec_hit = io_cycle &&
        (sec_cmd_hit || (upper_zero && io_a == sec_ctl)); // [RULE_02]
    wire sec_head_wr = io_cycle && hb_is_write_i && upper_zero &&
        (io_a == (sec_cmd | latm_pkg::IDE_HEAD_OFS));

    // Drive select seen by this access, including a write to head reg
    wire pri_slave = pri_head_wr ? hb_wdata_i[latm_pkg::BIT_HEAD_SEL]
                                 : pri_head_sel; // [RULE_03]
    wire sec_slave = sec_head_wr ? hb_wdata_i[latm_pkg::BIT_HEAD_SEL]
                                 : sec_head_sel; // [RULE_03]

    // Floppy controllers
    wire fdd_hit = io_cycle && upper_zero && (
        (io_a >= latm_pkg::FDD_PRI_LO && io_a <= latm_pkg::FDD_PRI_HI) ||
        (io_a == latm_pkg::FDD_PRI_X) ||
        (io_a >= latm_pkg::FDD_SEC_LO && io_a <= latm_pkg::FDD_SEC_HI) ||
        (io_a == latm_pkg::FDD_SEC_X)); // [RULE_05]

    // Parallel ports
    wire lpt_hit = io_cycle && upper_zero && (
        (io_a[15:3] == latm_pkg::LPT1_BASE[15:3]) ||
        (io_a[15:3] == latm_pkg::LPT2_BASE[15:3]) ||
        (io_a >= latm_pkg::LPT3_LO && io_a <= latm_pkg::LPT3_HI)); // [RULE_06]

    // Video IO and frame buffer
    wire vid_io_hit = io_cycle && upper_zero &&
        io_a >= latm_pkg::VID_IO_LO && io_a <= latm_pkg::VID_IO_HI;
    wire vid_mem_hit = mem_cycle &&
        hb_addr_i >= latm_pkg::VID_MEM_LO &&
        hb_addr_i <= latm_pkg::VID_MEM_HI;
    wire vid_hit = vid_io_hit || vid_mem_hit; // [RULE_07]

    // Keyboard controller
    wire kbd_hit = io_cycle && upper_zero &&
        (io_a == latm_pkg::KBD_DATA || io_a == latm_pkg::KBD_CMD); // [RULE_08]

    // Programmable range monitors
    logic [latm_pkg::NUM_TRAPS-1:0] range_evt [latm_pkg::NUM_RANGES];
    logic [latm_pkg::NUM_TRAPS-1:0] range_any;

    genvar g;
    generate
        for (g = 0; g < latm_pkg::NUM_RANGES; g = g + 1) begin : g_range
            wire [31:0] base = range_base_i[g*32 +: 32];
            wire [31:0] mask = range_mask_i[g*32 +: 32];
            wire [4:0] bit_no = latm_pkg::RANGE_BIT_MAP[g*5 +: 5];
            wire kind_ok = latm_pkg::RANGE_IS_MEM[g] ? mem_cycle
                                                    : io_cycle;
            wire hit = range_en_i[g] && kind_ok &&
                ((hb_addr_i & ~mask) == (base & ~mask)); // [RULE_09]
            assign range_evt[g] =
                hit ? (20'h00001 << bit_no) : 20'h00000;
        end
    endgenerate

    always_comb begin
        range_any = '0;
        for (int i = 0; i < latm_pkg::NUM_RANGES; i++) begin
            range_any = range_any | range_evt[i];
        end
    end

    // Trap event vector, one pulse per completed cycle
    logic [latm_pkg::NUM_TRAPS-1:0] trap_evt;
    always_comb begin
        trap_evt = range_any; // [RULE_20]
        trap_evt[0] = pri_hit & ~pri_slave;
        trap_evt[1] = pri_hit & pri_slave;
        trap_evt[2] = sec_hit & ~sec_slave;
        trap_evt[3] = sec_hit & sec_slave;
        trap_evt[latm_pkg::BIT_FLOPPY] = fdd_hit;
        trap_evt[latm_pkg::BIT_PARALLEL] = lpt_hit;
        trap_evt[latm_pkg::BIT_VIDEO] = vid_hit;
        trap_evt[latm_pkg::BIT_KEYBOARD] = kbd_hit;
        trap_evt[latm_pkg::BIT_USB] = usb_xfer_end_i; // [RULE_10]
    end

    // Register port decode
    wire sel_status = (io_addr_i == latm_pkg::OFS_TRAP_STATUS);
    wire sel_irq_en = (io_addr_i == latm_pkg::OFS_TRAP_IRQ_EN);
    wire sel_rld_en = (io_addr_i == latm_pkg::OFS_TRAP_RLD_EN);
    wire sel_irq_rld = (io_addr_i == latm_pkg::OFS_IRQ_RLD_EN);
    wire [31:0] be_mask = {{8{io_be_i[3]}}, {8{io_be_i[2]}},
                           {8{io_be_i[1]}}, {8{io_be_i[0]}}};
    wire [31:0] wr_bits = io_wdata_i & be_mask;

    // Status: set wins over clear
    wire [latm_pkg::NUM_TRAPS-1:0] clr_bits = (io_wr_i && sel_status)
        ? wr_bits[latm_pkg::NUM_TRAPS-1:0] : '0;
    wire [latm_pkg::NUM_TRAPS-1:0] next_trap_status =
        (trap_status & ~clr_bits) | trap_evt; // [RULE_11] [RULE_19]

    // Byte-enabled writes to the read-write registers
    wire [31:0] ien_full = {12'h000, trap_interrupt_enable};
    wire [31:0] rld_full = {10'h000, trap_timer_reload_enable};
    wire [31:0] irq_full = {16'h0000, irq_timer_reload_enable};
    wire [31:0] ien_wr = (ien_full & ~be_mask) | wr_bits;
    wire [31:0] rld_wr = (rld_full & ~be_mask) | wr_bits;
    wire [31:0] irq_wr = (irq_full & ~be_mask) | wr_bits;

    // Read mux, reserved bits read as zero
    wire [31:0] next_rdata =
        sel_status ? {12'h000, trap_status} :
        sel_irq_en ? ien_full :
        sel_rld_en ? rld_full :
        sel_irq_rld ? irq_full : latm_pkg::RST_VAL;

    // Interrupt routing from the updated status
    wire [latm_pkg::NUM_TRAPS-1:0] enabled_sts =
        next_trap_status & trap_interrupt_enable;
    wire any_enabled = |enabled_sts; // [RULE_13]
    wire next_sci = any_enabled & sci_routing_enable_i; // [RULE_12]
    wire next_smi = any_enabled & ~sci_routing_enable_i; // [RULE_12]

    // Timer reload sources
    wire trap_rld = |(trap_evt &
        trap_timer_reload_enable[latm_pkg::NUM_TRAPS-1:0]); // [RULE_14]
    wire ext_en = trap_timer_reload_enable[latm_pkg::BIT_EXT_SMI_RLD];
    wire ext_rise = external_smi_flag_i & ~ext_smi_prev;
    wire ext_rld = ext_en & ext_rise; // [RULE_15]
    wire next_hold = ext_en & external_smi_flag_i; // [RULE_15]
    wire bm_rld = trap_timer_reload_enable[latm_pkg::BIT_BMREQ_RLD] &
        (|bmreq_sync); // [RULE_16]
    wire irq_rld = |((irq_sync ^ irq_prev) &
        irq_timer_reload_enable); // [RULE_17]
    wire next_reload = trap_rld | ext_rld | bm_rld | irq_rld; // [RULE_18]

    // Synchronisers for pin-driven lines
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_meta <= '0;
            irq_sync <= '0;
            irq_prev <= '0;
            bmreq_meta <= '0;
            bmreq_sync <= '0;
        end else begin
            irq_meta <= irq_line_i;
            irq_sync <= irq_meta;
            irq_prev <= irq_sync;
            bmreq_meta <= bus_master_req_i;
            bmreq_sync <= bmreq_meta;
        end
    end

    // Drive select tracking
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pri_head_sel <= 1'b0;
            sec_head_sel <= 1'b0;
        end else begin
            pri_head_sel <= pri_slave; // [RULE_03]
            sec_head_sel <= sec_slave; // [RULE_03]
        end
    end

    // Trap status
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trap_status <= '0;
        end else begin
            trap_status <= next_trap_status; // [RULE_11]
        end
    end

    // Software enable registers
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trap_interrupt_enable <= '0;
            trap_timer_reload_enable <= '0;
            irq_timer_reload_enable <= '0;
        end else if (io_wr_i) begin
            if (sel_irq_en) begin
                trap_interrupt_enable <=
                    ien_wr[latm_pkg::NUM_TRAPS-1:0];
            end
            if (sel_rld_en) begin
                trap_timer_reload_enable <=
                    rld_wr[latm_pkg::RLD_BITS-1:0];
            end
            if (sel_irq_rld) begin
                irq_timer_reload_enable <=
                    irq_wr[latm_pkg::NUM_IRQS-1:0];
            end
        end
    end

    // Read data
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            io_rdata_o <= latm_pkg::RST_VAL;
        end else if (io_rd_i) begin
            io_rdata_o <= next_rdata;
        end
    end

    // Interrupt and timer outputs
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            smi_o <= 1'b0;
            sci_o <= 1'b0;
            any_trap_event_flag_o <= 1'b0;
            inactivity_reload_o <= 1'b0;
            inactivity_hold_o <= 1'b0;
            ext_smi_prev <= 1'b0;
        end else begin
            smi_o <= next_smi;
            sci_o <= next_sci;
            any_trap_event_flag_o <= any_enabled; // [RULE_13]
            inactivity_reload_o <= next_reload;
            inactivity_hold_o <= next_hold;
            ext_smi_prev <= external_smi_flag_i;
        end
    end

endmodule : latm_trap_monitor

// File: rtl/latm_pkg.sv
// Constants for the legacy access trap monitor.
// Assumes a single system clock shared with the host bus snoop.
package latm_pkg;
    // Register offsets in the power management IO block
    localparam logic [7:0] OFS_TRAP_STATUS = 8'hA8;
    localparam logic [7:0] OFS_TRAP_IRQ_EN = 8'hAC;
    localparam logic [7:0] OFS_TRAP_RLD_EN = 8'hB0;
    localparam logic [7:0] OFS_IRQ_RLD_EN = 8'hB4;
    // Field widths and reset values
    localparam int NUM_TRAPS = 20;
    localparam int RLD_BITS = 22;
    localparam int NUM_IRQS = 16;
    localparam int NUM_RANGES = 11;
    localparam int NUM_BMREQ = 4;
    localparam logic [31:0] RST_VAL = 32'h0000_0000;
    // Bit positions
    localparam int BIT_EXT_SMI_RLD = 20;
    localparam int BIT_BMREQ_RLD = 21;
    localparam int BIT_USB = 13;
    localparam int BIT_FLOPPY = 4;
    localparam int BIT_PARALLEL = 5;
    localparam int BIT_VIDEO = 9;
    localparam int BIT_KEYBOARD = 10;
    localparam int BIT_HEAD_SEL = 4;
    // Fixed IO and memory decodes
    localparam logic [15:0] IDE_PRI_CMD = 16'h01F0;
    localparam logic [15:0] IDE_PRI_CTL = 16'h03F6;
    localparam logic [15:0] IDE_SEC_CMD = 16'h0170;
    localparam logic [15:0] IDE_SEC_CTL = 16'h0376;
    localparam logic [15:0] IDE_HEAD_OFS = 16'h0006;
    localparam logic [15:0] IDE_NAT_CTL_OFS = 16'h0002;
    localparam logic [15:0] FDD_PRI_LO = 16'h03F0;
    localparam logic [15:0] FDD_PRI_HI = 16'h03F5;
    localparam logic [15:0] FDD_PRI_X = 16'h03F7;
    localparam logic [15:0] FDD_SEC_LO = 16'h0370;
    localparam logic [15:0] FDD_SEC_HI = 16'h0375;
    localparam logic [15:0] FDD_SEC_X = 16'h0377;
    localparam logic [15:0] LPT1_BASE = 16'h0378;
    localparam logic [15:0] LPT2_BASE = 16'h0278;
    localparam logic [15:0] LPT3_LO = 16'h03BC;
    localparam logic [15:0] LPT3_HI = 16'h03BF;
    localparam logic [15:0] VID_IO_LO = 16'h03B0;
    localparam logic [15:0] VID_IO_HI = 16'h03DF;
    localparam logic [31:0] VID_MEM_LO = 32'h000A_0000;
    localparam logic [31:0] VID_MEM_HI = 32'h000B_FFFF;
    localparam logic [15:0] KBD_DATA = 16'h0060;
    localparam logic [15:0] KBD_CMD = 16'h0064;
    // Programmable range slots mapped to trap bits
    localparam logic [NUM_RANGES*5-1:0] RANGE_BIT_MAP =
        {5'd19, 5'd18, 5'd17, 5'd16, 5'd15, 5'd14, 5'd12, 5'd11,
         5'd8, 5'd7, 5'd6};
    localparam logic [NUM_RANGES-1:0] RANGE_IS_MEM = 11'h600;
endpackage : latm_pkg

// File: verif/latm_trap_chk.sv
// Checker for the trap monitor: register map, routing, clear and hold.
// Assumes it is bound onto latm_trap_monitor and sees only its ports.
`timescale 1ns/1ps
module latm_trap_chk (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Watched inputs
    input wire logic hb_done_i,
    input wire logic usb_xfer_end_i,
    input wire logic external_smi_flag_i,
    input wire logic sci_routing_enable_i,
    input wire logic [7:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [3:0] io_be_i,
    input wire logic [31:0] io_wdata_i,
    // Watched outputs
    input wire logic [31:0] io_rdata_o,
    input wire logic smi_o,
    input wire logic sci_o,
    input wire logic any_trap_event_flag_o,
    input wire logic inactivity_hold_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence clear_all;
        io_wr_i && io_addr_i == 8'hA8 && io_be_i == 4'hF &&
        io_wdata_i[19:0] == 20'hFFFFF && !hb_done_i && !usb_xfer_end_i;
    endsequence
    sequence no_trap;
        !hb_done_i && !usb_xfer_end_i;
    endsequence
    AST_UNMAPPED_ZERO: assert property (io_rd_i && !(io_addr_i inside
        {8'hA8, 8'hAC, 8'hB0, 8'hB4}) |=> io_rdata_o == 32'h0)
        else $error("Unmapped read not zero");
    AST_STATUS_RSV: assert property (io_rd_i && io_addr_i == 8'hA8
        |=> io_rdata_o[31:20] == 12'h0) else $error("Status reserved set");
    AST_IRQ_EN_RSV: assert property (io_rd_i && io_addr_i == 8'hAC
        |=> io_rdata_o[31:20] == 12'h0) else $error("Enable reserved set");
    AST_RELOAD_RSV: assert property (io_rd_i && io_addr_i == 8'hB0
        |=> io_rdata_o[31:22] == 10'h0) else $error("Reload reserved set");
    AST_IRQ_RLD_RSV: assert property (io_rd_i && io_addr_i == 8'hB4
        |=> io_rdata_o[31:16] == 16'h0) else $error("IRQ reload reserved");
    AST_SCI_ROUTE: assert property (!sci_routing_enable_i |=> !sci_o)
        else $error("SCI raised while unrouted");
    AST_SMI_ROUTE: assert property (sci_routing_enable_i |=> !smi_o)
        else $error("SMI raised while routed to SCI");
    AST_EVENT_SUM: assert property ((smi_o || sci_o) == any_trap_event_flag_o)
        else $error("Event flag disagrees with interrupts");
    AST_CLEAR_DROP: assert property (clear_all ##1 no_trap
        |=> !any_trap_event_flag_o) else $error("Event survived clear");
    AST_HOLD_CAUSE: assert property (!external_smi_flag_i |=> !inactivity_hold_o)
        else $error("Hold without external flag");
endmodule : latm_trap_chk

bind latm_trap_monitor latm_trap_chk latm_trap_chk_i (.core_clk_i, .rstn_i,
    .hb_done_i, .usb_xfer_end_i, .external_smi_flag_i, .sci_routing_enable_i,
    .io_addr_i, .io_wr_i, .io_rd_i, .io_be_i, .io_wdata_i, .io_rdata_o,
    .smi_o, .sci_o, .any_trap_event_flag_o, .inactivity_hold_o);

// File: verif/latm_host_model.sv
// Host side model: completed bus cycles, bus master requests, IRQ pins.
// Assumes the caller waits for each task to return before the next one.
`timescale 1ns/1ps
module latm_host_model (
    // Clock
    input wire logic core_clk_i,
    // Host bus cycle
    output logic hb_done_o,
    output logic hb_is_mem_o,
    output logic hb_is_write_o,
    output logic [31:0] hb_addr_o,
    output logic [7:0] hb_wdata_o,
    // Request and interrupt pins
    output logic [3:0] bmreq_o,
    output logic [15:0] irq_o
);
    initial begin
        {hb_done_o, hb_is_mem_o, hb_is_write_o, bmreq_o, irq_o} = '0;
        hb_addr_o = 32'hFFFF_FFFF;
        hb_wdata_o = 8'hFF;
    end
    task cycle(input logic mem, input logic wr, input logic [31:0] a,
        input logic [7:0] d);
        @(negedge core_clk_i);
        hb_is_mem_o = mem;
        hb_is_write_o = wr;
        hb_addr_o = a;
        hb_wdata_o = d;
        hb_done_o = 1'b1; // One done pulse per access
        @(negedge core_clk_i);
        hb_done_o = 1'b0;
        hb_addr_o = ~a;
        hb_wdata_o = ~d;
    endtask : cycle
    task pins(input logic [3:0] b, input logic [15:0] q);
        @(negedge core_clk_i);
        bmreq_o = b;
        irq_o = q;
    endtask : pins
endmodule : latm_host_model

// File: verif/legacy_access_trap_monitor_bench.sv
// Self-checking bench for the trap monitor: map, decodes, routing, reload.
// Assumes the host model owns bus cycles and pins; 100 MHz clock.
`timescale 1ns/1ps
module legacy_access_trap_monitor_bench;
    logic core_clk_i, rstn_i, hb_done_i, hb_is_mem_i, hb_is_write_i, seen;
    logic [31:0] hb_addr_i, io_wdata_i, io_rdata_o, rv;
    logic [7:0] hb_wdata_i, io_addr_i;
    logic ide_pri_native_i, ide_sec_native_i, usb_xfer_end_i, io_wr_i;
    logic [15:0] ide_pri_cmd_base_i, ide_pri_ctl_base_i, irq_line_i;
    logic [15:0] ide_sec_cmd_base_i, ide_sec_ctl_base_i;
    logic [10:0] range_en_i;
    logic [351:0] range_base_i, range_mask_i;
    logic external_smi_flag_i, sci_routing_enable_i, io_rd_i, smi_o, sci_o;
    logic any_trap_event_flag_o, inactivity_reload_o, inactivity_hold_o;
    logic [3:0] bus_master_req_i, io_be_i;
    int miscompares, n_checks;
    localparam logic [31:0] DA [19] = '{32'h1F0, 32'h1F7, 32'h3F6, 32'h170,
        32'h376, 32'h3F0, 32'h3F7, 32'h375, 32'h377, 32'h378, 32'h27F,
        32'h3B0, 32'h3DF, 32'h60, 32'h64, 32'hA0000, 32'hBFFFF, 32'h1F8, 32'h61};
    localparam logic [19:0] DE [19] = '{20'h1, 20'h1, 20'h1, 20'h4, 20'h4,
        20'h10, 20'h10, 20'h10, 20'h10, 20'h20, 20'h20, 20'h200, 20'h200,
        20'h400, 20'h400, 20'h200, 20'h200, 20'h0, 20'h0};
    latm_trap_monitor latm_trap_monitor_i (.core_clk_i, .rstn_i, .hb_done_i,
        .hb_is_mem_i, .hb_is_write_i, .hb_addr_i, .hb_wdata_i,
        .ide_pri_native_i, .ide_pri_cmd_base_i, .ide_pri_ctl_base_i,
        .ide_sec_native_i, .ide_sec_cmd_base_i, .ide_sec_ctl_base_i,
        .range_en_i, .range_base_i, .range_mask_i, .usb_xfer_end_i,
        .external_smi_flag_i, .sci_routing_enable_i, .bus_master_req_i,
        .irq_line_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_be_i, .io_wdata_i,
        .io_rdata_o, .smi_o, .sci_o, .any_trap_event_flag_o,
        .inactivity_reload_o, .inactivity_hold_o);
    latm_host_model latm_host_model_i (.core_clk_i, .hb_done_o(hb_done_i),
        .hb_is_mem_o(hb_is_mem_i), .hb_is_write_o(hb_is_write_i),
        .hb_addr_o(hb_addr_i), .hb_wdata_o(hb_wdata_i),
        .bmreq_o(bus_master_req_i), .irq_o(irq_line_i));
    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word
    task chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_bit
    task reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge core_clk_i);
        io_addr_i = a;
        io_wdata_i = d;
        io_wr_i = 1'b1;
        @(negedge core_clk_i);
        io_wr_i = 1'b0;
    endtask : reg_wr
    task reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge core_clk_i);
        io_addr_i = a;
        io_rd_i = 1'b1;
        @(negedge core_clk_i);
        io_rd_i = 1'b0;
        d = io_rdata_o;
    endtask : reg_rd
    task trap(input logic m, input logic w, input logic [31:0] a,
        input logic [7:0] d, input logic [31:0] exp);
        reg_wr(8'hA8, 32'h000F_FFFF);
        latm_host_model_i.cycle(m, w, a, d);
        reg_rd(8'hA8, rv);
        chk_word(rv, exp);
    endtask : trap
    task watch(input int n);
        seen = 1'b0;
        repeat (n) begin
            @(negedge core_clk_i);
            seen = seen | inactivity_reload_o;
        end
    endtask : watch
    task t_regs;
        logic [7:0] ofs [4] = '{8'hAC, 8'hB0, 8'hB4, 8'hA4};
        logic [31:0] msk [4] = '{32'hFFFFF, 32'h3FFFFF, 32'hFFFF, 32'h0};
        reg_rd(8'hA8, rv);
        chk_word(rv, 32'h0);
        for (int i = 0; i < 4; i++) begin
            reg_rd(ofs[i], rv);
            chk_word(rv, 32'h0);
            reg_wr(ofs[i], 32'hFFFF_FFFF);
            reg_rd(ofs[i], rv);
            chk_word(rv, msk[i]);
            reg_wr(ofs[i], 32'h0);
        end
        io_be_i = 4'h1;
        reg_wr(8'hAC, 32'hFFFF_FFFF);
        io_be_i = 4'hF;
        reg_rd(8'hAC, rv);
        chk_word(rv, 32'hFF);
        reg_wr(8'hAC, 32'h0);
    endtask : t_regs
    task t_decode;
        for (int i = 0; i < 9; i++)
            trap(DA[i][19], 1'b0, DA[i], 8'h0, {12'h0, DE[i]});
        for (int i = 9; i < 19; i++)
            trap(DA[i][19], 1'b0, DA[i], 8'h0, {12'h0, DE[i]});
    endtask : t_decode
    task t_ide;
        trap(1'b0, 1'b1, 32'h1F6, 8'h10, 32'h2);
        trap(1'b0, 1'b0, 32'h1F0, 8'h00, 32'h2);
        trap(1'b0, 1'b1, 32'h176, 8'h10, 32'h8);
        trap(1'b0, 1'b1, 32'h1F6, 8'hEF, 32'h1);
        @(negedge core_clk_i);
        {ide_pri_cmd_base_i, ide_pri_ctl_base_i} = {16'h1000, 16'h2000};
        {ide_sec_cmd_base_i, ide_sec_ctl_base_i} = {16'h3000, 16'h3100};
        {ide_pri_native_i, ide_sec_native_i} = 2'h3;
        trap(1'b0, 1'b0, 32'h1004, 8'h00, 32'h1);
        trap(1'b0, 1'b0, 32'h2002, 8'h00, 32'h1);
        trap(1'b0, 1'b0, 32'h1F0, 8'h00, 32'h0);
        trap(1'b0, 1'b0, 32'h3007, 8'h00, 32'h8);
    endtask : t_ide
    task t_other;
        @(negedge core_clk_i);
        range_base_i[31:0] = 32'h500;
        range_mask_i[31:0] = 32'h7;
        {range_base_i[351:320], range_mask_i[351:320]} = {32'hD0000, 32'hFFF};
        range_en_i = 11'h401;
        trap(1'b0, 1'b0, 32'h507, 8'h00, 32'h40);
        trap(1'b1, 1'b0, 32'hD0123, 8'h00, 32'h80000);
        trap(1'b0, 1'b0, 32'h508, 8'h00, 32'h0);
        reg_wr(8'hA8, 32'h000F_FFFF);
        @(negedge core_clk_i);
        usb_xfer_end_i = 1'b1;
        @(negedge core_clk_i);
        usb_xfer_end_i = 1'b0;
        reg_rd(8'hA8, rv);
        chk_word(rv, 32'h2000);
    endtask : t_other
    task t_route;
        reg_wr(8'hAC, 32'h0000_0400);
        trap(1'b0, 1'b0, 32'h60, 8'h00, 32'h400);
        chk_bit(smi_o, 1'b1);
        chk_bit(any_trap_event_flag_o, 1'b1);
        sci_routing_enable_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        chk_bit(sci_o, 1'b1);
        chk_bit(smi_o, 1'b0);
        reg_wr(8'hA8, 32'h0000_0400);
        @(negedge core_clk_i);
        chk_bit(any_trap_event_flag_o, 1'b0);
        sci_routing_enable_i = 1'b0;
        trap(1'b0, 1'b0, 32'h3F0, 8'h00, 32'h10);
        chk_bit(any_trap_event_flag_o, 1'b0);
        reg_wr(8'hA8, 32'h000F_FFFF);
        fork
            latm_host_model_i.cycle(1'b0, 1'b0, 32'h64, 8'h00);
            reg_wr(8'hA8, 32'h0000_0400);
        join
        reg_rd(8'hA8, rv);
        chk_word(rv, 32'h400);
    endtask : t_route
    task t_reload;
        reg_wr(8'hB0, 32'h0030_0400);
        reg_wr(8'hB4, 32'h0000_0020);
        latm_host_model_i.cycle(1'b0, 1'b0, 32'h60, 8'h00);
        chk_bit(inactivity_reload_o, 1'b1);
        latm_host_model_i.cycle(1'b0, 1'b0, 32'h3F0, 8'h00);
        chk_bit(inactivity_reload_o, 1'b0);
        latm_host_model_i.pins(4'h1, 16'h0);
        watch(4);
        chk_bit(seen, 1'b1);
        latm_host_model_i.pins(4'h0, 16'h0);
        watch(4);
        latm_host_model_i.pins(4'h0, 16'h0020);
        watch(5);
        chk_bit(seen, 1'b1);
        latm_host_model_i.pins(4'h0, 16'h0060);
        watch(5);
        chk_bit(seen, 1'b0);
        external_smi_flag_i = 1'b1;
        watch(2);
        chk_bit(seen, 1'b1);
        watch(3);
        chk_bit(inactivity_hold_o, 1'b1);
        external_smi_flag_i = 1'b0;
        watch(2);
        chk_bit(inactivity_hold_o, 1'b0);
    endtask : t_reload
    task results;
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    initial begin
        {rstn_i, ide_pri_native_i, ide_sec_native_i, usb_xfer_end_i} = '0;
        {external_smi_flag_i, sci_routing_enable_i, io_wr_i, io_rd_i} = '0;
        {ide_pri_cmd_base_i, ide_pri_ctl_base_i} = '0;
        {ide_sec_cmd_base_i, ide_sec_ctl_base_i} = '0;
        {range_en_i, range_base_i, range_mask_i} = '0;
        {io_addr_i, io_wdata_i} = '0;
        io_be_i = 4'hF;
        repeat (6) @(negedge core_clk_i);
        rstn_i = 1'b1;
        t_regs;
        t_decode;
        t_ide;
        t_other;
        t_route;
        t_reload;
        results;
    end
    initial begin
        #200000;
        miscompares++;
        results;
    end
endmodule : legacy_access_trap_monitor_bench
